// File: rtl/adc_serial_ctrl.sv
/*
 * Serial interface and power-mode control of a two-channel SAR converter.
 * Host pins are asynchronous and are sampled by the 20 MHz clock; the serial
 * clock must stay below a quarter of that rate. The analog core supplies the
 * result bits as the approximation resolves them. Software reaches a control
 * and a status register over APB.
 */
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "adc_serial_map.svh"
module adc_serial_ctrl
    import adc_serial_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout_q,
    output logic dout_oe_q,
    input wire logic [11:0] result_in,
    output logic track_hold_q,
    output logic analog_power_q,
    output logic channel_select_bit_q,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q
);

    // ------------------------------------------------------------------------
    // Pin sampling and edge detection
    // ------------------------------------------------------------------------
    host_pins_t pins_s;
    host_pins_t pins_prev_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;

    sync_two_flop #(.WIDTH(3)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({cs_n, sclk, din}),
        .sync_out(pins_s)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pins_prev_q <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b1};
        end else begin
            pins_prev_q <= pins_s;
        end
    end

    assign cs_fall = pins_prev_q.cs_n & ~pins_s.cs_n;
    assign cs_rise = ~pins_prev_q.cs_n & pins_s.cs_n;
    assign sclk_fall = pins_prev_q.sclk & ~pins_s.sclk;
    assign sclk_rise = ~pins_prev_q.sclk & pins_s.sclk;

    // ------------------------------------------------------------------------
    // Frame and power control
    // ------------------------------------------------------------------------
    frame_state_t frame_q, frame_d;
    power_mode_t mode_q, mode_d;
    logic [4:0] cnt_q, cnt_d;
    logic [4:0] cnt_next;
    logic dout_d;
    logic dout_oe_d;
    logic track_hold_d;
    logic analog_power_d;
    logic channel_select_bit_d;
    logic conv_chan_q, conv_chan_d;
    logic track_arm_q, track_arm_d;
    logic aborted_q, aborted_d;
    logic [15:0] din_word_q, din_word_d;
    logic res10_q, res10_d;

    // Output bit for a position of the frame, 0 being the bit driven at select fall
    function automatic logic frame_bit(input logic [3:0] idx, input logic ten, input logic chan,
                                       input logic [11:0] res);
        logic b;
        b = 1'b0;
        if (idx == `BIT_CHAN_A || idx == `BIT_CHAN_B) begin
            b = chan;
        end else if (idx >= `BIT_DATA_FIRST) begin
            if (!ten) begin
                b = res[`IDX12_TOP - idx];
            end else if (idx <= `BIT_DATA10_LAST) begin
                b = res[`IDX10_TOP - idx];
            end
        end
        return b;
    endfunction

    assign cnt_next = cnt_q + 5'h01;

    always_comb begin
        frame_d = frame_q;
        mode_d = mode_q;
        cnt_d = cnt_q;
        dout_d = dout_q;
        dout_oe_d = dout_oe_q;
        track_hold_d = track_hold_q;
        analog_power_d = analog_power_q;
        channel_select_bit_d = channel_select_bit_q;
        conv_chan_d = conv_chan_q;
        track_arm_d = track_arm_q;
        aborted_d = aborted_q;
        din_word_d = din_word_q;
        if (cs_fall) begin
            // A select fall always opens a new frame, even mid-frame
            frame_d = frame_active;
            cnt_d = 5'h00;
            dout_oe_d = 1'b1;
            dout_d = 1'b0;
            track_hold_d = 1'b1;
            conv_chan_d = channel_select_bit_q;
            track_arm_d = 1'b0;
            aborted_d = 1'b0;
            if (mode_q == mode_down) begin
                mode_d = mode_powering;
                analog_power_d = 1'b1;
            end
        end else if (cs_rise) begin
            frame_d = frame_idle;
            dout_oe_d = 1'b0;
            track_arm_d = 1'b0;
            if (frame_q == frame_active) begin
                aborted_d = 1'b1;
                // Mode decided from the fall count at select rise
                if (mode_q == mode_powering) begin
                    if (cnt_q < `CNT_PD_HIGH) begin
                        mode_d = mode_down;
                        analog_power_d = 1'b0;
                        track_hold_d = 1'b1;
                    end else begin
                        mode_d = mode_normal;
                        track_hold_d = 1'b0;
                    end
                end else if (cnt_q >= `CNT_PD_LOW && cnt_q < `CNT_PD_HIGH) begin
                    mode_d = mode_down;
                    analog_power_d = 1'b0;
                    track_hold_d = 1'b1;
                end else begin
                    // Too early to power down (glitch guard) or late abort
                    track_hold_d = 1'b0;
                end
            end
        end else if (sclk_fall && frame_q == frame_active) begin
            cnt_d = cnt_next;
            din_word_d = {din_word_q[14:0], pins_s.din};
            if (cnt_next == `CNT_CHAN_BIT) begin
                channel_select_bit_d = pins_s.din;
            end
            if (mode_q == mode_powering && cnt_next == `CNT_PU_TRACK) begin
                track_hold_d = 1'b0;
            end
            if (cnt_next == `CNT_TRACK_ARM) begin
                track_arm_d = 1'b1;
            end
            if (cnt_next == `CNT_FRAME_END) begin
                frame_d = frame_done;
                dout_oe_d = 1'b0;
                if (mode_q == mode_powering) begin
                    mode_d = mode_normal;
                    track_hold_d = 1'b0;
                end
            end else begin
                dout_d = frame_bit(cnt_next[3:0], res10_q, conv_chan_q, result_in);
            end
        end else if (sclk_rise && track_arm_q) begin
            track_arm_d = 1'b0;
            track_hold_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_q <= frame_idle;
            mode_q <= mode_normal;
            cnt_q <= 5'h00;
            dout_q <= 1'b0;
            dout_oe_q <= 1'b0;
            track_hold_q <= 1'b0;
            analog_power_q <= 1'b1;
            channel_select_bit_q <= 1'b0;
            conv_chan_q <= 1'b0;
            track_arm_q <= 1'b0;
            aborted_q <= 1'b0;
            din_word_q <= 16'h0000;
        end else begin
            frame_q <= frame_d;
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            dout_q <= dout_d;
            dout_oe_q <= dout_oe_d;
            track_hold_q <= track_hold_d;
            analog_power_q <= analog_power_d;
            channel_select_bit_q <= channel_select_bit_d;
            conv_chan_q <= conv_chan_d;
            track_arm_q <= track_arm_d;
            aborted_q <= aborted_d;
            din_word_q <= din_word_d;
        end
    end

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    // Zero-wait answer: data is fetched in the setup cycle so pready can come
    // from a flop; status is therefore one cycle old when it reaches the host.
    logic [31:0] prdata_d;
    logic pready_d;
    logic pslverr_d;
    logic addr_ok;

    assign addr_ok = (paddr == `REG_CTRL_OFS) || (paddr == `REG_STATUS_OFS);

    always_comb begin
        res10_d = res10_q;
        prdata_d = 32'h0000_0000;
        pready_d = psel & ~penable;
        pslverr_d = psel & ~penable & ~addr_ok;
        if (psel && !penable && !pwrite) begin
            if (paddr == `REG_CTRL_OFS) begin
                prdata_d = {31'h0000_0000, res10_q};
            end else if (paddr == `REG_STATUS_OFS) begin
                prdata_d = {din_word_q, 3'h0, cnt_q, 2'h0, aborted_q, conv_chan_q,
                            channel_select_bit_q, frame_q == frame_active, mode_q};
            end
        end
        if (psel && penable && pready_q && pwrite && paddr == `REG_CTRL_OFS) begin
            res10_d = pwdata[`CTRL_RES10_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            res10_q <= `CTRL_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            res10_q <= res10_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic quiet_edge;
    assign quiet_edge = sclk_fall && frame_q == frame_active && !cs_fall && !cs_rise;

    sequence s_fall_at(logic [4:0] n);
        quiet_edge && cnt_q == n;
    endsequence

    chk_open_frame: assert property (cs_fall |=> dout_oe_q && !dout_q && track_hold_q)
        else $error("frame did not open on select fall");
    chk_first_zero: assert property (s_fall_at(5'h00) |=> dout_oe_q && !dout_q)
        else $error("second leading zero missing");
    chk_release_16: assert property (s_fall_at(5'h0F) |=> !dout_oe_q && frame_q == frame_done)
        else $error("output not released on 16th fall");
    chk_track_after: assert property (track_arm_q && sclk_rise && !cs_fall && !cs_rise |=> !track_hold_q)
        else $error("no return to track after 13 falls");
    chk_third_bit: assert property (s_fall_at(5'h02) |=> channel_select_bit_q == $past(pins_s.din))
        else $error("channel not taken from third input bit");
    chk_chan_bit: assert property (s_fall_at(5'h01) |=> dout_q == conv_chan_q)
        else $error("channel bit does not match converted channel");
    chk_chan_id: assert property (s_fall_at(5'h02) |=> dout_q == conv_chan_q)
        else $error("invalid bit does not match channel");
    chk_trail_zero: assert property (s_fall_at(5'h0D) && res10_q |=> !dout_q)
        else $error("10-bit trailing zero missing");
    chk_pd_window: assert property (cs_rise && frame_q == frame_active && mode_q == mode_normal
                                    && cnt_q >= `CNT_PD_LOW && cnt_q < `CNT_PD_HIGH |=> mode_q == mode_down
                                    && !analog_power_q && !dout_oe_q)
        else $error("no power-down in window");
    chk_no_early_pd: assert property (cs_rise && frame_q == frame_active && mode_q == mode_normal
                                      && cnt_q < `CNT_PD_LOW |=> mode_q == mode_normal && analog_power_q)
        else $error("power-down before second fall");
    chk_late_abort: assert property (cs_rise && frame_q == frame_active && mode_q == mode_normal
                                     && cnt_q >= `CNT_PD_HIGH |=> analog_power_q && !dout_oe_q && aborted_q)
        else $error("late rise did not abort cleanly");
    chk_pu_back: assert property (cs_rise && mode_q == mode_powering && frame_q == frame_active
                                  && cnt_q < `CNT_PD_HIGH |=> mode_q == mode_down)
        else $error("early rise did not return to power-down");
    chk_pu_late: assert property (cs_rise && mode_q == mode_powering && frame_q == frame_active
                                  && cnt_q >= `CNT_PD_HIGH |=> mode_q == mode_normal && analog_power_q)
        else $error("late rise did not finish power-up");
    chk_pu_track: assert property (s_fall_at(5'h04) && mode_q == mode_powering |=> !track_hold_q)
        else $error("power-up frame did not track at fifth fall");
    chk_pu_done: assert property (s_fall_at(5'h0F) && mode_q == mode_powering |=> mode_q == mode_normal)
        else $error("not fully powered after 16 clocks");
    chk_pd_off: assert property (mode_q == mode_down |-> !analog_power_q)
        else $error("analog powered in power-down");

endmodule

// File: rtl/adc_serial_map.svh
/*
 * Offsets, field positions, reset values and counts of the serial and power
 * control of the two-channel converter. Assumes a 32-bit APB slave with a
 * 12-bit byte address.
 */
// Notes on behaviour
// - Select fall: hold, sample, convert, drive output
// - First zero on select fall, then per edge
// - Track after 13 falls; release on 16th
// - Capture serial input on each clock fall
// - Third input bit picks next channel only
// - Input shifts in while result shifts out
// - Output bits change on clock falling edges
// - 12-bit: zeros, channel, channel, twelve result bits
// - 10-bit: zeros, channel, channel, ten bits, zeros
// - Rise after tenth fall: abort, stay powered
// - Rise between second and tenth: power down
// - Rise before second fall: stay normal
// - Power-down switches analog circuitry off
// - Select fall starts power-up; continue past tenth
// - Early rise during power-up: back down
// - Fully powered after 16 clocks of dummy
// - Power-up frame returns to track at fifth
`ifndef ADC_SERIAL_MAP_SVH
`define ADC_SERIAL_MAP_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define REG_CTRL_OFS 12'h000
`define REG_STATUS_OFS 12'h004
`define CTRL_RES10_BIT 0
`define CTRL_RESET 1'b0

// ----------------------------------------------------------------------------
// Frame counts, in serial clock falling edges
// ----------------------------------------------------------------------------
`define CNT_PD_LOW 5'h02
`define CNT_PD_HIGH 5'h0A
`define CNT_CHAN_BIT 5'h03
`define CNT_PU_TRACK 5'h05
`define CNT_TRACK_ARM 5'h0D
`define CNT_FRAME_END 5'h10
`define BIT_CHAN_A 4'h2
`define BIT_CHAN_B 4'h3
`define BIT_DATA_FIRST 4'h4
`define BIT_DATA10_LAST 4'hD
`define IDX12_TOP 4'hF
`define IDX10_TOP 4'hD

`endif

// File: rtl/adc_serial_pkg.sv
/*
 * Types shared by the serial and power control: frame and mode states and the
 * bundle of pins coming from the host.
 * Assumes nothing of its surroundings.
 */
package adc_serial_pkg;

    typedef enum logic [1:0] {
        frame_idle,
        frame_active,
        frame_done
    } frame_state_t;

    typedef enum logic [1:0] {
        mode_normal,
        mode_down,
        mode_powering
    } power_mode_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } host_pins_t;

endpackage

// File: rtl/sync_two_flop.sv
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes the inputs are asynchronous to clock; only the second stage is read.
 */
`timescale 1ns/10ps
module sync_two_flop #(
    parameter int WIDTH = 3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q[i] <= 1'b1;
                    stable_q[i] <= 1'b1;
                end else begin
                    meta_q[i] <= async_in[i];
                    stable_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sync_out = stable_q;

endmodule

// File: tb/host_serial_model.sv
/*
 * Behavioural host serial master: frames the converter with select, clock and
 * channel word, and captures the returned frame bits. A released output reads
 * as the inverse of its last bit, so a bit taken while undriven is caught.
 * Assumes the 20 MHz system clock; the serial clock is made at 2.5 MHz.
 */
`timescale 1ns/10ps
module host_serial_model (
    input wire logic clock,
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout_q,
    input wire logic dout_oe_q,
    input wire logic track_hold_q
);
    // ------------------------------------------------------------------
    // Idle: select high, serial clock parked high between frames
    // ------------------------------------------------------------------
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end

    // ------------------------------------------------------------------
    // One frame of n falling edges; select always rises at the end
    // ------------------------------------------------------------------
    task automatic run_frame(input int n, input logic [15:0] w, output logic [15:0] got,
                             output logic [2:0] hold);
        got = 16'h0000;
        hold = 3'h0;
        cs_n <= 1'b0;
        din <= w[15];
        repeat (8) @(posedge clock);
        for (int k = 1; k <= n; k++) begin
            got[16-k] = dout_oe_q ? dout_q : ~dout_q;
            if (k == 1) hold[2] = track_hold_q;
            if (k == 6) hold[1] = track_hold_q;
            if (k == 14) hold[0] = track_hold_q;
            sclk <= 1'b0;
            repeat (4) @(posedge clock);
            sclk <= 1'b1;
            if (k < 16) din <= w[15-k];
            repeat (4) @(posedge clock);
        end
        cs_n <= 1'b1;
        din <= ~din;
        // Quiet time before the next select fall
        repeat (8) @(posedge clock);
    endtask
endmodule

// File: tb/test_adc_serial_ctrl.sv
/*
 * Self-checking bench of the serial and power-mode control: APB register
 * accesses and serial frames from the host model, checked against the frame
 * format and the select-rise mode windows.
 * Assumes the design's zero-wait APB slave and its 3-4 clock pin latency.
 */
`timescale 1ns/10ps
`include "adc_serial_map.svh"
module test_adc_serial_ctrl
    import adc_serial_pkg::*;
;
    logic clock;
    logic rst_n;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout_q;
    logic dout_oe_q;
    logic [11:0] result_in;
    logic track_hold_q;
    logic analog_power_q;
    logic channel_select_bit_q;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] r;
    logic e;
    logic [15:0] got;
    logic [2:0] hold;

    adc_serial_ctrl dut (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout_q(dout_q), .dout_oe_q(dout_oe_q), .result_in(result_in), .track_hold_q(track_hold_q),
        .analog_power_q(analog_power_q), .channel_select_bit_q(channel_select_bit_q),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q));

    host_serial_model host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout_q(dout_q), .dout_oe_q(dout_oe_q), .track_hold_q(track_hold_q));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Leading edge keeps a release and the next setup on different edges
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int t;
        t = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready_q !== 1'b1 && t < 16) begin
            @(posedge clock);
            t++;
        end
        if (t == 16) errors++;
        rd = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [15:0] frame_exp(input logic ch, input logic ten, input logic [11:0] v);
        return ten ? {2'b00, ch, ch, v[9:0], 2'b00} : {2'b00, ch, ch, v};
    endfunction

    // ------------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        result_in = 12'hA5C;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (5) @(posedge clock);
        check({dout_oe_q, track_hold_q, analog_power_q, channel_select_bit_q}, 4'h2);
        apb(1'b0, `REG_CTRL_OFS, 32'h0, r, e);
        check(r, 32'h00000000);
        apb(1'b1, 12'h008, 32'hFFFFFFFF, r, e);
        check(e, 1'b1);
        apb(1'b1, `REG_STATUS_OFS, 32'hFFFFFFFF, r, e);
        apb(1'b0, `REG_STATUS_OFS, 32'h0, r, e);
        check(r, 32'h00000000);
        // 12-bit frames; the channel word picks the next channel only
        host.run_frame(16, 16'h2000, got, hold);
        check(got, frame_exp(1'b0, 1'b0, 12'hA5C));
        check(hold, 3'h6);
        check(dout_oe_q, 1'b0);
        check(channel_select_bit_q, 1'b1);
        apb(1'b0, `REG_STATUS_OFS, 32'h0, r, e);
        check(r[31:16], 16'h2000);
        check({r[3], r[2]}, 2'b10);
        result_in <= 12'h3C9;
        host.run_frame(16, 16'hDFFF, got, hold);
        check(got, frame_exp(1'b1, 1'b0, 12'h3C9));
        check(channel_select_bit_q, 1'b0);
        // 10-bit frame format
        apb(1'b1, `REG_CTRL_OFS, 32'h1, r, e);
        apb(1'b0, `REG_CTRL_OFS, 32'h0, r, e);
        check(r, 32'h00000001);
        result_in <= 12'hF96;
        host.run_frame(16, 16'h0000, got, hold);
        check(got, frame_exp(1'b0, 1'b1, 12'hF96));
        // Select-rise windows
        host.run_frame(1, 16'h0000, got, hold);
        check({analog_power_q, dout_oe_q}, 2'b10);
        host.run_frame(12, 16'h0000, got, hold);
        check({analog_power_q, dout_oe_q}, 2'b10);
        apb(1'b0, `REG_STATUS_OFS, 32'h0, r, e);
        check({r[5], r[1:0]}, 3'h4);
        host.run_frame(5, 16'h0000, got, hold);
        check({analog_power_q, dout_oe_q}, 2'b00);
        apb(1'b0, `REG_STATUS_OFS, 32'h0, r, e);
        check(r[1:0], 2'h1);
        // Power-up attempt cut short returns to power-down
        host.run_frame(8, 16'h0000, got, hold);
        check(hold, 3'h4);
        check(analog_power_q, 1'b0);
        // Dummy ended early after the tenth fall
        host.run_frame(12, 16'h0000, got, hold);
        check(analog_power_q, 1'b1);
        apb(1'b0, `REG_STATUS_OFS, 32'h0, r, e);
        check(r[1:0], 2'h0);
        // Full 16-clock dummy, then a valid frame
        host.run_frame(3, 16'h0000, got, hold);
        check(analog_power_q, 1'b0);
        host.run_frame(16, 16'h0000, got, hold);
        check({hold, analog_power_q}, 4'h9);
        result_in <= 12'h2B7;
        host.run_frame(16, 16'h0000, got, hold);
        check(got, frame_exp(1'b0, 1'b1, 12'h2B7));
        tally_and_finish();
    end
endmodule
